// [fcq_host.sv]
// Host controller that issues command and query sequences to a parallel flash.
//
// Contract
// - Host issues only valid command sequences, and refuses an invalid one by setting the refused status flag.
// - Host writes reset on timeout status, or to leave autoselect mode.
// - On buffer abort status without timeout status, host issues the three-write abort reset sequence.
// - Autoselect is two unlock writes then command, from array mode only.
// - Query mode is entered by 98h written to word 55h when ready.
module fcq_host
	import fcq_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   flashCeN,
	output logic                   flashWeN,
	output logic                   flashOeN,
	output logic      [ADDR_W-1:0] flashAddr,
	output logic      [DATA_W-1:0] flashDqOut,
	output logic                   flashDqOe,
	input  wire logic [DATA_W-1:0] flashDqIn
);

	// ------------------------------------------------------------------
	// Sequence helpers
	// ------------------------------------------------------------------
	function automatic logic [ADDR_W+DATA_W:0] stepInfo(fcq_op_t op, logic [1:0] step,
			logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
		logic [ADDR_W+DATA_W:0] r;
		r = {1'b1, a, d};
		case (op)
			OP_READ:  r = {1'b0, a, d};
			OP_RESET: r = {1'b1, a, CMD_RESET};
			OP_QUERY: r = {1'b1, ADDR_QUERY, CMD_QUERY};
			OP_AUTOSEL, OP_ABORT_RST: begin
				case (step)
					2'h0:    r = {1'b1, ADDR_UNLOCK1, CMD_UNLOCK1};
					2'h1:    r = {1'b1, ADDR_UNLOCK2, CMD_UNLOCK2};
					default: r = {1'b1, ADDR_UNLOCK1,
						(op == OP_AUTOSEL) ? CMD_AUTOSEL : CMD_RESET};
				endcase
			end
			default: r = {1'b1, a, d};
		endcase
		return r;
	endfunction

	function automatic logic [1:0] lastStep(fcq_op_t op);
		return (op == OP_AUTOSEL || op == OP_ABORT_RST) ? 2'h2 : 2'h0;
	endfunction

	// Autoselect is only offered from array mode; nothing here tracks erase
	// suspend, so that entry path is left to plain raw writes.
	function automatic logic opAllowed(fcq_op_t op, fcq_mode_t mode);
		case (op)
			OP_WRITE, OP_READ, OP_RESET, OP_ABORT_RST, OP_QUERY: return 1'b1;
			OP_AUTOSEL: return mode == MODE_ARRAY;
			default:    return 1'b0;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	logic rstMeta_reg, rstN_reg;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rstMeta_reg <= 1'b0;
			rstN_reg    <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstN_reg    <= rstMeta_reg;
		end
	end

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	fcq_sq_t           sq_reg, sq_next;
	fcq_op_t           op_reg, op_next, newOp;
	fcq_mode_t         mode_reg, mode_next;
	logic [1:0]        step_reg, step_next;
	logic [ADDR_W-1:0] addr_reg, addr_next, cyAddr_reg, cyAddr_next;
	logic [DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
	logic [DATA_W-1:0] cyData_reg, cyData_next, cyRdata;
	logic              cyStart_reg, cyStart_next, cyWrite_reg, cyWrite_next, cyDone;
	logic              autoRec_reg, autoRec_next;
	logic              timeout_reg, timeout_next, abort_reg, abort_next;
	logic              refused_reg, refused_next;
	logic [31:0]       prdata_reg, prdata_next;
	logic              pready_reg, pready_next, pslverr_reg, pslverr_next;
	logic              apbWr, cmdWr, stClr;

	assign apbWr = psel && penable && pready_reg && pwrite;
	assign cmdWr = apbWr && paddr == REG_CMD;
	assign stClr = apbWr && paddr == REG_STATUS;
	assign newOp = fcq_op_t'(pwdata[CMD_OP_LSB +: 3]);

	// ------------------------------------------------------------------
	// Register slave
	// ------------------------------------------------------------------
	always_comb begin
		prdata_next  = 32'h00000000;
		pready_next  = 1'b0;
		pslverr_next = 1'b0;
		if (psel && !penable) begin
			pready_next = 1'b1;
			case (paddr)
				REG_CMD:    prdata_next = {27'h0, autoRec_reg, 1'b0, op_reg};
				REG_ADDR:   prdata_next = {9'h000, addr_reg};
				REG_WDATA:  prdata_next = {16'h0000, wdata_reg};
				REG_RDATA:  prdata_next = {16'h0000, rdata_reg};
				REG_STATUS: prdata_next = {26'h0, refused_reg, abort_reg, timeout_reg,
					mode_reg, sq_reg != SQ_IDLE};
				default:    pslverr_next = 1'b1;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------------
	always_comb begin
		logic setT, setA, setR;
		setT         = 1'b0;
		setA         = 1'b0;
		setR         = 1'b0;
		sq_next      = sq_reg;
		op_next      = op_reg;
		mode_next    = mode_reg;
		step_next    = step_reg;
		addr_next    = addr_reg;
		wdata_next   = wdata_reg;
		rdata_next   = rdata_reg;
		autoRec_next = autoRec_reg;
		cyStart_next = 1'b0;
		cyWrite_next = cyWrite_reg;
		cyAddr_next  = cyAddr_reg;
		cyData_next  = cyData_reg;
		if (apbWr && paddr == REG_ADDR) begin
			addr_next = pwdata[ADDR_W-1:0];
		end
		if (apbWr && paddr == REG_WDATA) begin
			wdata_next = pwdata[DATA_W-1:0];
		end
		case (sq_reg)
			SQ_IDLE: begin
				if (cmdWr) begin
					if (opAllowed(newOp, mode_reg)) begin
						op_next      = newOp;
						autoRec_next = pwdata[CMD_AUTO_BIT];
						step_next    = 2'h0;
						sq_next      = SQ_ISSUE;
					end else begin
						setR = 1'b1;
					end
				end
			end
			SQ_ISSUE: begin
				setR = cmdWr;
				{cyWrite_next, cyAddr_next, cyData_next} =
					stepInfo(op_reg, step_reg, addr_reg, wdata_reg);
				cyStart_next = 1'b1;
				sq_next      = SQ_WAIT;
			end
			SQ_WAIT: begin
				setR = cmdWr;
				if (cyDone) begin
					if (step_reg != lastStep(op_reg)) begin
						step_next = step_reg + 2'h1;
						sq_next   = SQ_ISSUE;
					end else begin
						sq_next = SQ_IDLE;
						case (op_reg)
							OP_RESET, OP_ABORT_RST: mode_next = MODE_ARRAY;
							OP_AUTOSEL:             mode_next = MODE_AUTOSEL;
							OP_QUERY:               mode_next = MODE_QUERY;
							default:                mode_next = mode_reg;
						endcase
						if (op_reg == OP_READ) begin
							rdata_next = cyRdata;
							if (autoRec_reg && cyRdata[DQ_TIMEOUT_BIT]) begin
								setT      = 1'b1;
								op_next   = OP_RESET;
								step_next = 2'h0;
								sq_next   = SQ_ISSUE;
							end else if (autoRec_reg && cyRdata[DQ_ABORT_BIT]) begin
								setA      = 1'b1;
								op_next   = OP_ABORT_RST;
								step_next = 2'h0;
								sq_next   = SQ_ISSUE;
							end
						end
					end
				end
			end
			default: sq_next = SQ_IDLE;
		endcase
		// A flag raised in the same cycle as its clear survives the clear.
		timeout_next = (timeout_reg & ~(stClr & pwdata[ST_TIMEOUT])) | setT;
		abort_next   = (abort_reg & ~(stClr & pwdata[ST_ABORT])) | setA;
		refused_next = (refused_reg & ~(stClr & pwdata[ST_REFUSED])) | setR;
	end

	always_ff @(posedge ref_clk or negedge rstN_reg) begin
		if (!rstN_reg) begin
			sq_reg      <= SQ_IDLE;
			op_reg      <= OP_NONE;
			mode_reg    <= MODE_ARRAY;
			step_reg    <= 2'h0;
			addr_reg    <= ADDR_RESET_VAL;
			wdata_reg   <= WDATA_RESET_VAL;
			rdata_reg   <= WDATA_RESET_VAL;
			autoRec_reg <= 1'b0;
			cyStart_reg <= 1'b0;
			cyWrite_reg <= 1'b0;
			cyAddr_reg  <= ADDR_RESET_VAL;
			cyData_reg  <= WDATA_RESET_VAL;
			timeout_reg <= 1'b0;
			abort_reg   <= 1'b0;
			refused_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			sq_reg      <= sq_next;
			op_reg      <= op_next;
			mode_reg    <= mode_next;
			step_reg    <= step_next;
			addr_reg    <= addr_next;
			wdata_reg   <= wdata_next;
			rdata_reg   <= rdata_next;
			autoRec_reg <= autoRec_next;
			cyStart_reg <= cyStart_next;
			cyWrite_reg <= cyWrite_next;
			cyAddr_reg  <= cyAddr_next;
			cyData_reg  <= cyData_next;
			timeout_reg <= timeout_next;
			abort_reg   <= abort_next;
			refused_reg <= refused_next;
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;

	// ------------------------------------------------------------------
	// Flash bus cycles
	// ------------------------------------------------------------------
	fcq_cycle u_cycle (
		.clk       (ref_clk),
		.rstN      (rstN_reg),
		.start     (cyStart_reg),
		.isWrite   (cyWrite_reg),
		.addr      (cyAddr_reg),
		.wdata     (cyData_reg),
		.dqIn      (flashDqIn),
		.ceN       (flashCeN),
		.weN       (flashWeN),
		.oeN       (flashOeN),
		.flashAddr (flashAddr),
		.dqOut     (flashDqOut),
		.dqOe      (flashDqOe),
		.rdata     (cyRdata),
		.done      (cyDone)
	);

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstN_reg);

	sequence s_firstUnlock;
		##1 (cyStart_reg && cyWrite_reg && cyAddr_reg == ADDR_UNLOCK1 &&
			cyData_reg == CMD_UNLOCK1);
	endsequence

	property p_autoselEntry;
		(sq_reg == SQ_IDLE && cmdWr && newOp == OP_AUTOSEL && mode_reg == MODE_ARRAY)
			|=> s_firstUnlock;
	endproperty
	a_autoselEntry: assert property (p_autoselEntry) else $error("autoselect unlock missing");

	property p_queryCmd;
		(cyStart_reg && op_reg == OP_QUERY)
			|-> cyWrite_reg && cyAddr_reg == ADDR_QUERY && cyData_reg == CMD_QUERY;
	endproperty
	a_queryCmd: assert property (p_queryCmd) else $error("query command malformed");

	property p_resetCmd;
		(cyStart_reg && op_reg == OP_RESET) |-> cyWrite_reg && cyData_reg == CMD_RESET;
	endproperty
	a_resetCmd: assert property (p_resetCmd) else $error("reset command malformed");

	property p_refuse;
		(sq_reg == SQ_IDLE && cmdWr && !opAllowed(newOp, mode_reg))
			|=> refused_reg && sq_reg == SQ_IDLE;
	endproperty
	a_refuse: assert property (p_refuse) else $error("invalid operation not refused");

	property p_busyRefuse;
		(sq_reg != SQ_IDLE && cmdWr) |=> refused_reg;
	endproperty
	a_busyRefuse: assert property (p_busyRefuse) else $error("command while busy not refused");

	property p_timeoutReset;
		(sq_reg == SQ_WAIT && cyDone && op_reg == OP_READ && autoRec_reg &&
			cyRdata[DQ_TIMEOUT_BIT]) |=> sq_reg == SQ_ISSUE && op_reg == OP_RESET && timeout_reg;
	endproperty
	a_timeoutReset: assert property (p_timeoutReset) else $error("no reset after timeout");

	property p_abortReset;
		(sq_reg == SQ_WAIT && cyDone && op_reg == OP_READ && autoRec_reg &&
			!cyRdata[DQ_TIMEOUT_BIT] && cyRdata[DQ_ABORT_BIT])
			|=> sq_reg == SQ_ISSUE && op_reg == OP_ABORT_RST && abort_reg ##0 s_firstUnlock;
	endproperty
	a_abortReset: assert property (p_abortReset) else $error("no abort reset sequence");

	property p_modeHome;
		(sq_reg == SQ_WAIT && cyDone && op_reg == OP_RESET) |=> mode_reg == MODE_ARRAY;
	endproperty
	a_modeHome: assert property (p_modeHome) else $error("mode not array after reset");

	property p_apbAnswer;
		(psel && !penable) |=> pready_reg ##1 !pready_reg;
	endproperty
	a_apbAnswer: assert property (p_apbAnswer) else $error("register answer timing wrong");

endmodule

// [fcq_pkg.sv]
// Shared constants and types of the flash command and query host controller.
package fcq_pkg;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int ADDR_W = 23;
	localparam int DATA_W = 16;
	localparam int APB_AW = 8;

	// ------------------------------------------------------------------
	// Register map of the controller
	// ------------------------------------------------------------------
	localparam logic [APB_AW-1:0] REG_CMD    = 8'h00;
	localparam logic [APB_AW-1:0] REG_ADDR   = 8'h04;
	localparam logic [APB_AW-1:0] REG_WDATA  = 8'h08;
	localparam logic [APB_AW-1:0] REG_RDATA  = 8'h0C;
	localparam logic [APB_AW-1:0] REG_STATUS = 8'h10;

	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_AUTO_BIT = 4;
	localparam int ST_BUSY      = 0;
	localparam int ST_MODE_LSB  = 1;
	localparam int ST_TIMEOUT   = 3;
	localparam int ST_ABORT     = 4;
	localparam int ST_REFUSED   = 5;

	localparam logic [ADDR_W-1:0] ADDR_RESET_VAL  = 23'h000000;
	localparam logic [DATA_W-1:0] WDATA_RESET_VAL = 16'h0000;

	// ------------------------------------------------------------------
	// Operations, device modes and states
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NONE      = 3'h0,
		OP_WRITE     = 3'h1,
		OP_READ      = 3'h2,
		OP_RESET     = 3'h3,
		OP_AUTOSEL   = 3'h4,
		OP_QUERY     = 3'h5,
		OP_ABORT_RST = 3'h6
	} fcq_op_t;

	typedef enum logic [1:0] {
		MODE_ARRAY   = 2'h0,
		MODE_AUTOSEL = 2'h1,
		MODE_QUERY   = 2'h2
	} fcq_mode_t;

	typedef enum logic [2:0] {
		SQ_IDLE  = 3'b001,
		SQ_ISSUE = 3'b010,
		SQ_WAIT  = 3'b100
	} fcq_sq_t;

	typedef enum logic [3:0] {
		CY_IDLE  = 4'b0001,
		CY_SETUP = 4'b0010,
		CY_PULSE = 4'b0100,
		CY_HOLD  = 4'b1000
	} fcq_cy_t;

	// ------------------------------------------------------------------
	// Flash command codes and addresses
	// ------------------------------------------------------------------
	localparam logic [DATA_W-1:0] CMD_RESET   = 16'h00F0;
	localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 16'h00AA;
	localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 16'h0055;
	localparam logic [DATA_W-1:0] CMD_AUTOSEL = 16'h0090;
	localparam logic [DATA_W-1:0] CMD_QUERY   = 16'h0098;
	localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 23'h000555;
	localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 23'h0002AA;
	localparam logic [ADDR_W-1:0] ADDR_QUERY   = 23'h000055;
	localparam int DQ_TIMEOUT_BIT = 5;
	localparam int DQ_ABORT_BIT   = 1;

	// ------------------------------------------------------------------
	// Bus cycle timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 10;
	localparam int T_ADDR_SETUP_NS  = 10;
	localparam int T_WE_PULSE_NS    = 40;
	localparam int T_READ_ACCESS_NS = 100;
	localparam int T_CE_HOLD_NS     = 20;
	localparam int SETUP_CYC = (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_CYC = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYC  = (T_READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC  = (T_CE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// [fcq_cycle.sv]
// Single asynchronous flash bus cycle engine: one read or one write per start.
module fcq_cycle
	import fcq_pkg::*;
#(
	parameter int SETUP_N = SETUP_CYC,
	parameter int WRITE_N = WRITE_CYC,
	parameter int READ_N  = READ_CYC,
	parameter int HOLD_N  = HOLD_CYC
) (
	input  wire logic              clk,
	input  wire logic              rstN,
	input  wire logic              start,
	input  wire logic              isWrite,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [DATA_W-1:0] dqIn,
	output logic                   ceN,
	output logic                   weN,
	output logic                   oeN,
	output logic      [ADDR_W-1:0] flashAddr,
	output logic      [DATA_W-1:0] dqOut,
	output logic                   dqOe,
	output logic      [DATA_W-1:0] rdata,
	output logic                   done
);

	// The counters are four bits wide, so longer phases cannot be served.
	if (SETUP_N < 1 || WRITE_N < 1 || READ_N < 1 || HOLD_N < 1 ||
		SETUP_N > 16 || WRITE_N > 16 || READ_N > 16 || HOLD_N > 16) begin : g_badCounts
		$error("fcq_cycle: cycle counts must lie in 1..16");
	end

	fcq_cy_t           cy_reg, cy_next;
	logic [3:0]        cnt_reg, cnt_next;
	logic              wr_reg, wr_next;
	logic              ceN_reg, ceN_next, weN_reg, weN_next, oeN_reg, oeN_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [DATA_W-1:0] dqOut_reg, dqOut_next, rdata_reg, rdata_next;
	logic              dqOe_reg, dqOe_next, done_reg, done_next;
	logic [DATA_W-1:0] dqMeta_reg, dqSync_reg;

	// ------------------------------------------------------------------
	// Cycle sequencing
	// ------------------------------------------------------------------
	// The sampled data is two cycles old because of the synchroniser; the read
	// strobe is not lengthened to cover it, so data is taken two cycles before READ_N ends.
	always_comb begin
		cy_next    = cy_reg;
		cnt_next   = cnt_reg;
		wr_next    = wr_reg;
		ceN_next   = ceN_reg;
		weN_next   = weN_reg;
		oeN_next   = oeN_reg;
		addr_next  = addr_reg;
		dqOut_next = dqOut_reg;
		dqOe_next  = dqOe_reg;
		rdata_next = rdata_reg;
		done_next  = 1'b0;
		case (cy_reg)
			CY_IDLE: begin
				if (start) begin
					cy_next    = CY_SETUP;
					ceN_next   = 1'b0;
					addr_next  = addr;
					dqOut_next = wdata;
					dqOe_next  = isWrite;
					wr_next    = isWrite;
					cnt_next   = 4'(SETUP_N - 1);
				end
			end
			CY_SETUP: begin
				if (cnt_reg == 4'h0) begin
					cy_next = CY_PULSE;
					if (wr_reg) begin
						weN_next = 1'b0;
						cnt_next = 4'(WRITE_N - 1);
					end else begin
						oeN_next = 1'b0;
						cnt_next = 4'(READ_N - 1);
					end
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			CY_PULSE: begin
				if (cnt_reg == 4'h0) begin
					cy_next  = CY_HOLD;
					weN_next = 1'b1;
					oeN_next = 1'b1;
					cnt_next = 4'(HOLD_N - 1);
					if (!wr_reg) begin
						rdata_next = dqSync_reg;
					end
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			CY_HOLD: begin
				if (cnt_reg == 4'h0) begin
					cy_next   = CY_IDLE;
					ceN_next  = 1'b1;
					dqOe_next = 1'b0;
					done_next = 1'b1;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			default: begin
				cy_next   = CY_IDLE;
				ceN_next  = 1'b1;
				weN_next  = 1'b1;
				oeN_next  = 1'b1;
				dqOe_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cy_reg     <= CY_IDLE;
			cnt_reg    <= 4'h0;
			wr_reg     <= 1'b0;
			ceN_reg    <= 1'b1;
			weN_reg    <= 1'b1;
			oeN_reg    <= 1'b1;
			addr_reg   <= '0;
			dqOut_reg  <= '0;
			dqOe_reg   <= 1'b0;
			rdata_reg  <= '0;
			done_reg   <= 1'b0;
			dqMeta_reg <= '0;
			dqSync_reg <= '0;
		end else begin
			cy_reg     <= cy_next;
			cnt_reg    <= cnt_next;
			wr_reg     <= wr_next;
			ceN_reg    <= ceN_next;
			weN_reg    <= weN_next;
			oeN_reg    <= oeN_next;
			addr_reg   <= addr_next;
			dqOut_reg  <= dqOut_next;
			dqOe_reg   <= dqOe_next;
			rdata_reg  <= rdata_next;
			done_reg   <= done_next;
			dqMeta_reg <= dqIn;
			dqSync_reg <= dqMeta_reg;
		end
	end

	assign ceN       = ceN_reg;
	assign weN       = weN_reg;
	assign oeN       = oeN_reg;
	assign flashAddr = addr_reg;
	assign dqOut     = dqOut_reg;
	assign dqOe      = dqOe_reg;
	assign rdata     = rdata_reg;
	assign done      = done_reg;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_writePulse;
		@(posedge clk) disable iff (!rstN)
		$fell(weN_reg) |-> (!weN_reg && !ceN_reg && oeN_reg)[*4] ##1 weN_reg;
	endproperty
	a_writePulse: assert property (p_writePulse) else $error("write strobe width wrong");

	property p_writeHold;
		@(posedge clk) disable iff (!rstN)
		$rose(weN_reg) |-> dqOe_reg && !ceN_reg && $stable(addr_reg) && $stable(dqOut_reg);
	endproperty
	a_writeHold: assert property (p_writeHold) else $error("write data not held at strobe rise");

endmodule

// [fcq_flash_model.sv]
// Behavioural flash device: command, autoselect and query decoding.
module fcq_flash_model
	import fcq_pkg::*;
#(
	parameter logic [DATA_W-1:0] MFR_ID = 16'h0013,
	parameter logic [DATA_W-1:0] DEV_ID = 16'h0022
) (
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] dIn,
	input  wire logic              ceN,
	input  wire logic              weN,
	input  wire logic              oeN,
	output logic      [DATA_W-1:0] dOut
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [ADDR_W-1:0] latA = '0;
	logic [1:0]        md  = 2'h0;
	logic [1:0]        unl = 2'h0;
	wire               stb = ceN | weN;
	function automatic logic [DATA_W-1:0] rd(input logic [ADDR_W-1:0] a);
		logic [7:0] q;
		q = a[7:0];
		if (md == 2'h0)
			return a[15:0];
		if (md == 2'h1)
			return (q == 8'h00) ? MFR_ID :
				(q == 8'h01 || q == 8'h0E || q == 8'h0F) ? DEV_ID + q :
				(q == 8'h02) ? {15'h0000, a[15]} : 16'h0000;
		case (q)
			8'h27: return 16'h0018;
			8'h2A: return 16'h0005;
			8'h2C, 8'h30, 8'h47, 8'h4C, 8'h50: return 16'h0001;
			8'h2D: return 16'h00FF;
			8'h40: return 16'h0050;
			8'h41: return 16'h0052;
			8'h42: return 16'h0049;
			8'h43: return 16'h0031;
			8'h44: return 16'h0033;
			8'h46: return 16'h0002;
			8'h4F: return 16'h0004;
			default: return 16'h0000;
		endcase
	endfunction
	// Released pins show the inverse so a stale value never passes as read data.
	always_comb dOut = (!ceN && !oeN) ? rd(addr) : ~rd(addr);
	always @(negedge stb) latA = addr;
	always @(posedge stb) begin
		if (dIn == CMD_RESET)
			md = 2'h0;
		if (dIn == CMD_QUERY && latA == ADDR_QUERY)
			md = 2'h2;
		if (unl == 2'h2 && dIn == CMD_AUTOSEL && latA == ADDR_UNLOCK1 && md == 2'h0)
			md = 2'h1;
		// An unknown strobe edge at power-up must fall through to the idle unlock state.
		if (unl == 2'h0 && dIn == CMD_UNLOCK1 && latA == ADDR_UNLOCK1)
			unl = 2'h1;
		else if (unl == 2'h1 && dIn == CMD_UNLOCK2 && latA == ADDR_UNLOCK2)
			unl = 2'h2;
		else
			unl = 2'h0;
	end
endmodule

// [fcq_host_test.sv]
// Self-checking bench of the flash command and query host controller.
module fcq_host_test
	import fcq_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] MFR = 16'h0013; // Arbitrary identity value.
	localparam logic [15:0] DEV = 16'h0022; // Arbitrary identity value.
	localparam logic [23:0] QT [19] = '{24'h270018, 24'h2A0005, 24'h2B0000, 24'h2C0001,
		24'h2D00FF, 24'h300001, 24'h310000, 24'h400050, 24'h410052, 24'h420049, 24'h430031,
		24'h440033, 24'h460002, 24'h470001, 24'h4A0000, 24'h4B0000, 24'h4C0001, 24'h4F0004,
		24'h500001};
	logic              ref_clk = 1'b0;
	logic              resetn  = 1'b0;
	logic              psel    = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite  = 1'b0;
	logic [7:0]        paddr   = 8'h00;
	logic [31:0]       pwdata  = 32'h00000000;
	logic [31:0]       prdata, r, seed = 32'h0001593E;
	logic              pready, pslverr, ceN, weN, oeN, dqOe, err;
	logic [ADDR_W-1:0] fAddr;
	logic [DATA_W-1:0] dqOut, devOut;
	wire  [DATA_W-1:0] dqBus = dqOe ? dqOut : devOut;
	int                failCount = 0, checkCount = 0, cyc = 0;
	fcq_host dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flashCeN(ceN), .flashWeN(weN), .flashOeN(oeN),
		.flashAddr(fAddr), .flashDqOut(dqOut), .flashDqOe(dqOe), .flashDqIn(dqBus));
	fcq_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) dev (.addr(fAddr), .dIn(dqBus),
		.ceN(ceN), .weN(weN), .oeN(oeN), .dOut(devOut));
	initial forever #5 ref_clk = ~ref_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic tallyAndFinish();
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			failCount++;
			tallyAndFinish();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			failCount++;
			$display("unexpected at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	// The global cycle ceiling bounds this busy poll.
	task automatic op(input logic [2:0] o, input logic auto);
		apb(1'b1, REG_CMD, {27'h0, auto, 1'b0, o});
		do apb(1'b0, REG_STATUS, 32'h0); while (r[ST_BUSY] !== 1'b0);
	endtask
	task automatic st(input logic [31:0] s);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(r & 32'h0000003E, s);
	endtask
	task automatic rdF(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
		apb(1'b1, REG_ADDR, {9'h000, a});
		op(OP_READ, 1'b0);
		apb(1'b0, REG_RDATA, 32'h0);
		chk(r, {16'h0000, exp});
	endtask
	task automatic rec(input logic [ADDR_W-1:0] a, input logic [31:0] s);
		apb(1'b1, REG_STATUS, 32'h38);
		op(OP_AUTOSEL, 1'b0);
		apb(1'b1, REG_ADDR, {9'h000, a});
		op(OP_READ, 1'b1);
		st(s);
		rdF(23'h000001, 16'h0001);
	endtask
	initial begin
		logic [31:0] a;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		st(32'h0);
		repeat (3) begin
			a = rnd() & 32'h007FFFDD;
			rdF(a[22:0], a[15:0]);
		end
		op(OP_AUTOSEL, 1'b0);
		st(32'h2);
		rdF(23'h000000, MFR);
		rdF(23'h7F0000, MFR);
		rdF(23'h000001, DEV + 16'h0001);
		rdF(23'h00000E, DEV + 16'h000E);
		rdF(23'h00000F, DEV + 16'h000F);
		rdF(23'h008002, 16'h0001);
		rdF(23'h010002, 16'h0000);
		op(OP_QUERY, 1'b0);
		st(32'h4);
		foreach (QT[i]) rdF({15'h0000, QT[i][23:16]}, QT[i][15:0]);
		op(OP_AUTOSEL, 1'b0);
		st(32'h24);
		apb(1'b1, REG_STATUS, 32'h20);
		op(OP_NONE, 1'b0);
		st(32'h24);
		apb(1'b1, REG_STATUS, 32'h20);
		apb(1'b1, REG_CMD, {29'h0, OP_READ});
		op(OP_READ, 1'b0);
		st(32'h24);
		op(3'h7, 1'b0);
		a = rnd();
		apb(1'b1, REG_ADDR, a);
		apb(1'b0, REG_ADDR, 32'h0);
		chk(r, a & 32'h007FFFFF);
		op(OP_RESET, 1'b0);
		st(32'h20);
		rdF(23'h000123, 16'h0123);
		rec(23'h000001, 32'h8);
		rec(23'h000000, 32'h10);
		apb(1'b1, REG_ADDR, {9'h000, ADDR_QUERY});
		apb(1'b1, REG_WDATA, {16'h0000, CMD_QUERY});
		apb(1'b0, REG_WDATA, 32'h0);
		chk(r, {16'h0000, CMD_QUERY});
		op(OP_WRITE, 1'b0);
		rdF(23'h000027, 16'h0018);
		op(OP_ABORT_RST, 1'b0);
		apb(1'b0, REG_CMD, 32'h0);
		chk(r, {29'h0, OP_ABORT_RST});
		rdF(23'h000027, 16'h0027);
		apb(1'b0, 8'h14, 32'h0);
		chk({r[30:0], err}, 32'h1);
		tallyAndFinish();
	end
endmodule
